// ===== hdl/sar_adc_control.sv
`timescale 1ns/1ps
// Contract
// (R1) busy output high exactly while converting, low otherwise
// (R2) qualified start is convert_start_n latched while chip select low
// (R3) frame_sync ignored while chip select is high
// (R4) serial clock gated by chip select; data shifts on rising edge
// (R5) msb presented at frame start; others leave on rising clock
// (R6) power down pin resets all state and holds it; the input synchronizers and synced cs_n, cv and pd are not reset
// (R7) format select low: straight binary; high: two's complement
// (R8) qualified start falling while sampling begins a conversion
// (R9) sampling starts from wait or conversion end when start high
// (R10) start condition at conversion end goes straight to sampling
// (R11) no start condition at conversion end: wait until it appears
// (R12) conversion end with qualified start low enters nap state
// (R13) leaving nap needs longer acquisition before next conversion
// (R14) qualified start falling during conversion aborts, then wait
// (R15) aborted conversion reads fixed code 3fc00
// (R16) readout frames allowed anytime, independent of conversion
// (R17) readout during conversion returns previous result
// (R18) host keeps interface quiet around start and busy fall
// (R19) host avoids frame start near busy falling edge
// (R20) chip select framing: msb at select fall, next after sclk
// (R21) frame sync framing: msb at frame sync rise
// (R22) frame sync high at busy fall reloads new msb
// (R23) new frame during active frame restarts from msb
// (R24) 18-bit result msb first; extra clocks harmless
// (R25) conversion timing from internal clock, not serial clock
`include "sar_ctl_regs.svh"
module sar_adc_control
    import sar_ctl_pkg::*;
#(
    parameter int RESULT_WIDTH = `RESULT_WIDTH
) (
    // system
    input wire logic I_CLK,
    input wire logic I_RST,
    // control pins
    input wire logic I_CONVERT_START_N,
    input wire logic I_CS_N,
    input wire logic I_FRAME_SYNC,
    input wire logic I_POWER_DOWN_PIN,
    input wire logic I_OUTPUT_FORMAT_SELECT,
    // analog core result
    input wire logic [RESULT_WIDTH-1:0] I_CORE_RESULT,
    // serial link
    input wire logic I_SCLK,
    output logic O_SDO,
    output logic O_SDO_OE_N,
    // status
    output logic O_BUSY,
    output logic O_NAP,
    output logic O_SAMPLING
);
    logic [2:0] cs_sync;
    logic [2:0] cv_sync;
    logic [2:0] pd_sync;
    logic cs_n;
    logic cv;
    logic pd;
    logic qual;
    logic qual_d;
    logic qual_fall;
    logic rst_all;
    conv_state_t state;
    conv_state_t next_state;
    logic [`CNT_WIDTH-1:0] cnt;
    logic conv_done;
    logic conv_abort;
    logic nap_seen;
    logic [RESULT_WIDTH-1:0] result;
    logic result_tog;
    logic [RESULT_WIDTH-1:0] fmt_core;

    // three-stage sync, change accepted when stages 2 and 3 agree
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            cs_sync <= 3'h7;
            cv_sync <= 3'h7;
            pd_sync <= 3'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], I_CS_N};
            cv_sync <= {cv_sync[1:0], I_CONVERT_START_N};
            pd_sync <= {pd_sync[1:0], I_POWER_DOWN_PIN};
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            cs_n <= 1'b1;
            cv <= 1'b1;
            pd <= 1'b0;
        end else begin
            if (cs_sync[1] == cs_sync[2]) cs_n <= cs_sync[2];
            if (cv_sync[1] == cv_sync[2]) cv <= cv_sync[2];
            if (pd_sync[1] == pd_sync[2]) pd <= pd_sync[2];
        end
    end

    assign rst_all = pd; // [R6]

    // qualified start: transparent latch on chip select low
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            qual <= 1'b1;
            qual_d <= 1'b1;
        end else if (rst_all) begin
            qual <= 1'b1;
            qual_d <= 1'b1;
        end else begin
            if (!cs_n) qual <= cv; // [R2]
            qual_d <= qual;
        end
    end

    assign qual_fall = qual_d && !qual;

    assign conv_done = (state == ST_CONVERT) &&
        (cnt == `CNT_WIDTH'(`CONV_CYCLES - 1)); // [R25]
    assign conv_abort = (state == ST_CONVERT) && qual_fall; // [R14]

    // conversion state machine on the internal clock
    always_comb begin
        next_state = state;
        case (state)
            ST_WAIT: begin
                if (qual && !cs_n) next_state = ST_SAMPLE; // [R9]
            end
            ST_NAP: begin
                if (qual && !cs_n) next_state = ST_SAMPLE; // [R9]
            end
            ST_SAMPLE: begin
                if (qual_fall) next_state = ST_CONVERT; // [R8]
            end
            ST_CONVERT: begin
                if (conv_abort) begin
                    next_state = ST_WAIT; // [R14]
                end else if (conv_done) begin
                    if (qual && !cs_n) begin
                        next_state = ST_SAMPLE; // [R10]
                    end else if (!qual) begin
                        next_state = ST_NAP; // [R12]
                    end else begin
                        next_state = ST_WAIT; // [R11]
                    end
                end
            end
            default: next_state = ST_WAIT;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state <= ST_WAIT;
        end else if (rst_all) begin
            state <= ST_WAIT; // [R6]
        end else begin
            state <= next_state;
        end
    end

    // conversion / acquisition cycle counter
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            cnt <= '0;
        end else if (rst_all || state != next_state) begin
            cnt <= '0;
        end else if (cnt != '1) begin
            cnt <= cnt + `CNT_WIDTH'(1);
        end
    end

    // remembers that this acquisition follows a nap
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            nap_seen <= 1'b0;
        end else if (rst_all) begin
            nap_seen <= 1'b0;
        end else if (state == ST_NAP) begin
            nap_seen <= 1'b1; // [R13]
        end else if (state == ST_CONVERT) begin
            nap_seen <= 1'b0;
        end
    end

    // sampling flag stays high until acquisition time has elapsed
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_SAMPLING <= 1'b0;
        end else if (rst_all) begin
            O_SAMPLING <= 1'b0;
        end else begin
            O_SAMPLING <= (next_state == ST_SAMPLE) &&
                (nap_seen ? (cnt < `CNT_WIDTH'(`NAP_ACQ_CYCLES)) // [R13]
                          : (cnt < `CNT_WIDTH'(`ACQ_CYCLES)));
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_BUSY <= 1'b0;
            O_NAP <= 1'b0;
        end else if (rst_all) begin
            O_BUSY <= 1'b0;
            O_NAP <= 1'b0;
        end else begin
            O_BUSY <= (next_state == ST_CONVERT); // [R1]
            O_NAP <= (next_state == ST_NAP);
        end
    end

    assign fmt_core = I_OUTPUT_FORMAT_SELECT ?
        {~I_CORE_RESULT[RESULT_WIDTH-1], I_CORE_RESULT[RESULT_WIDTH-2:0]}
        : I_CORE_RESULT; // [R7]

    // result register updates at busy fall; toggle tells the link
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            result <= '0;
            result_tog <= 1'b0;
        end else if (rst_all) begin
            result <= '0;
            result_tog <= 1'b0;
        end else if (conv_abort) begin
            result <= RESULT_WIDTH'(`ABORT_CODE); // [R15]
            result_tog <= ~result_tog;
        end else if (conv_done) begin
            result <= fmt_core; // [R17]
            result_tog <= ~result_tog;
        end
    end

    // link domain, clocked by the gated serial clock
    logic [RESULT_WIDTH-1:0] shreg;
    logic [2:0] tog_sync;
    logic first_fall;
    logic [4:0] bit_cnt;
    logic fs_q;
    logic frame_rst;
    logic fs_gated;

    assign fs_gated = I_FRAME_SYNC && !I_CS_N; // [R3]
    assign frame_rst = I_CS_N || I_POWER_DOWN_PIN;

    // new result toggle crossing into the link clock
    always_ff @(posedge I_SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            tog_sync <= 3'h0;
            fs_q <= 1'b0;
        end else begin
            tog_sync <= {tog_sync[1:0], result_tog};
            fs_q <= fs_gated;
        end
    end

    always_ff @(negedge I_SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            first_fall <= 1'b0;
        end else if (fs_gated && !fs_q) begin
            first_fall <= 1'b0; // [R23]
        end else begin
            first_fall <= 1'b1; // [R20]
        end
    end

    // shift register: msb preloaded, later bits on rising sclk
    always_ff @(posedge I_SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            shreg <= '0;
            bit_cnt <= '0;
        end else if ((fs_gated && !fs_q) || bit_cnt == '0) begin
            shreg <= result; // [R21] [R23] [R5]
            bit_cnt <= 5'h1;
        end else if (fs_gated && bit_cnt >= 5'h3 &&
                     tog_sync[2] != tog_sync[1]) begin
            shreg <= result; // [R22]
            bit_cnt <= 5'h1;
        end else if (first_fall && bit_cnt < 5'(RESULT_WIDTH)) begin
            shreg <= {shreg[RESULT_WIDTH-2:0], 1'b0}; // [R4] [R24]
            bit_cnt <= bit_cnt + 5'h1;
        end
    end

    // msb shows directly while no edge has loaded the shifter [R16]
    assign O_SDO = (bit_cnt == '0) ? result[RESULT_WIDTH-1]
                                   : shreg[RESULT_WIDTH-1];
    assign O_SDO_OE_N = I_CS_N || I_POWER_DOWN_PIN;
endmodule

// ===== hdl/sar_ctl_regs.svh
`ifndef SAR_CTL_REGS_SVH
`define SAR_CTL_REGS_SVH
`define RESULT_WIDTH 18
`define ABORT_CODE 18'h3fc00
`define CONV_TIME_NS 1160
`define CLK_PERIOD_NS 10
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define ACQ_TIME_NS 300
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))
`define NAP_ACQ_TIME_NS 600
`define NAP_ACQ_CYCLES \
    ((`NAP_ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))
`define CNT_WIDTH 8
`endif

// ===== hdl/sar_ctl_pkg.sv
package sar_ctl_pkg;
    typedef enum logic [2:0] {
        ST_WAIT,
        ST_SAMPLE,
        ST_CONVERT,
        ST_NAP
    } conv_state_t;
endpackage

// ===== dv/sar_adc_control_assertions.sv
`timescale 1ns/1ps
`include "sar_ctl_regs.svh"
module sar_adc_control_assertions (
    // system
    input wire logic I_CLK,
    input wire logic I_RST,
    // pins
    input wire logic I_CONVERT_START_N,
    input wire logic I_CS_N,
    input wire logic I_POWER_DOWN_PIN,
    // outputs
    input wire logic O_SDO_OE_N,
    input wire logic O_BUSY,
    input wire logic O_NAP,
    input wire logic O_SAMPLING
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    logic [7:0] busy_cnt;
    // length of the current busy pulse
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= O_BUSY ? busy_cnt + 8'h01 : 8'h00;
        end
    end
    sequence start_high_s;
        (I_CONVERT_START_N && !I_CS_N && !I_POWER_DOWN_PIN)[*8];
    endsequence
    sequence start_low_s;
        (!I_CONVERT_START_N && !I_CS_N && !I_POWER_DOWN_PIN)[*8];
    endsequence
    busy_excl_a: assert property (O_BUSY |-> !O_NAP && !O_SAMPLING)
        else $error("busy together with nap or sampling");
    busy_bound_a: assert property (busy_cnt <= `CONV_CYCLES)
        else $error("busy longer than a conversion");
    pd_reset_a: assert property (I_POWER_DOWN_PIN[*6]
        |-> !O_BUSY && !O_NAP && !O_SAMPLING)
        else $error("state kept in power down");
    sdo_release_a: assert property (I_CS_N |-> O_SDO_OE_N)
        else $error("data driven while deselected");
    conv_start_a: assert property ($rose(O_BUSY)
        |-> !$past(I_CONVERT_START_N) && !O_NAP)
        else $error("busy without start fall");
    back_to_back_a: assert property (start_high_s ##0 $fell(O_BUSY)
        |-> ##[0:2] O_SAMPLING)
        else $error("no sampling after conversion");
    nap_entry_a: assert property (start_low_s ##0 $fell(O_BUSY)
        |-> ##[0:2] O_NAP)
        else $error("no nap after conversion");
    wait_hold_a: assert property (start_low_s ##0 !O_SAMPLING
        |=> !O_SAMPLING)
        else $error("sampling without start high");
endmodule
bind sar_adc_control sar_adc_control_assertions chk_u (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .I_CONVERT_START_N(I_CONVERT_START_N),
    .I_CS_N(I_CS_N),
    .I_POWER_DOWN_PIN(I_POWER_DOWN_PIN),
    .O_SDO_OE_N(O_SDO_OE_N),
    .O_BUSY(O_BUSY),
    .O_NAP(O_NAP),
    .O_SAMPLING(O_SAMPLING)
);

// ===== dv/host_model.sv
`timescale 1ns/1ps
module host_model (
    // clock and data
    input wire logic i_clk,
    input wire logic i_sdo,
    // pins to the converter
    output logic o_convert_start_n = 1'b0,
    output logic o_cs_n = 1'b1,
    output logic o_frame_sync = 1'b1,
    output logic o_sclk = 1'b0
);
    // set start and select, then hold n cycles
    task automatic pins(input logic cvs, input logic cs, input int n);
        @(posedge i_clk);
        o_convert_start_n <= cvs;
        o_cs_n <= cs;
        repeat (n) @(posedge i_clk);
    endtask
    // frame of n bits, clock still outside it; away from busy fall
    task automatic read(input int n, output logic [17:0] d);
        d = 18'h00000;
        pins(o_convert_start_n, 1'b1, 8);
        pins(o_convert_start_n, 1'b0, 0);
        #83;
        d[17] = i_sdo;
        o_sclk = 1'b1;
        #80 o_sclk = 1'b0;
        for (int i = 16; i > 17 - n; i--) begin
            #80 o_sclk = 1'b1;
            #80 o_sclk = 1'b0;
            d[i] = i_sdo;
        end
        pins(o_convert_start_n, 1'b1, 2);
    endtask
    // frame restarted by a frame sync pulse; first two bits after it
    task automatic restart(output logic [1:0] b);
        pins(o_convert_start_n, 1'b1, 8);
        pins(o_convert_start_n, 1'b0, 0);
        repeat (2) begin
            #80 o_sclk = 1'b1;
            #80 o_sclk = 1'b0;
        end
        o_frame_sync = 1'b0;
        #80 o_sclk = 1'b1;
        #80 o_sclk = 1'b0;
        o_frame_sync = 1'b1;
        #80 o_sclk = 1'b1;
        #40 b[1] = i_sdo;
        #40 o_sclk = 1'b0;
        #80 o_sclk = 1'b1;
        #40 b[0] = i_sdo;
        #40 o_sclk = 1'b0;
        pins(o_convert_start_n, 1'b1, 2);
    endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "sar_ctl_regs.svh"
module tb_top;
    logic clk, rst, pd, fmt, cvs, cs_n, fs, sclk, sdo, oe_n, busy, nap, smp;
    logic [17:0] core, d, last;
    int fails, checks, n;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sar_adc_control dut_u (.I_CLK(clk), .I_RST(rst),
        .I_CONVERT_START_N(cvs), .I_CS_N(cs_n), .I_FRAME_SYNC(fs),
        .I_POWER_DOWN_PIN(pd), .I_OUTPUT_FORMAT_SELECT(fmt),
        .I_CORE_RESULT(core), .I_SCLK(sclk), .O_SDO(sdo),
        .O_SDO_OE_N(oe_n), .O_BUSY(busy), .O_NAP(nap), .O_SAMPLING(smp));
    host_model host_u (.i_clk(clk), .i_sdo(sdo), .o_convert_start_n(cvs),
        .o_cs_n(cs_n), .o_frame_sync(fs), .o_sclk(sclk));
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl);
        n = 0;
        while (busy !== lvl && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(18'(n < 300), 18'h1);
    endtask
    // sample long, then start a conversion
    task automatic convert();
        host_u.pins(1'b1, 1'b0, 8);
        check(18'(smp), 18'h1);
        host_u.pins(1'b1, 1'b0, `NAP_ACQ_CYCLES);
        host_u.pins(1'b0, 1'b0, 0);
        wait_busy(1'b1);
    endtask
    task automatic t_nap(input logic f, input logic [17:0] v);
        @(posedge clk);
        fmt <= f;
        core <= v;
        convert();
        wait_busy(1'b0);
        check(18'(n), 18'(`CONV_CYCLES));
        repeat (3) @(negedge clk);
        check(18'(nap), 18'h1);
        host_u.read(18, d);
        last = f ? {~v[17], v[16:0]} : v;
        check(d, last);
        check(18'(oe_n), 18'h1);
        $display("nap test done");
    endtask
    task automatic t_b2b();
        host_u.restart(d[1:0]);
        check(18'(d[1:0]), 18'(last[17:16]));
        core <= 18'h3c0f1;
        convert();
        host_u.read(5, d);
        check(18'(d[17:13]), 18'(last[17:13]));
        host_u.pins(1'b1, 1'b0, 0);
        wait_busy(1'b0);
        repeat (2) @(negedge clk);
        check(18'(smp), 18'h1);
        host_u.read(18, d);
        check(d, 18'h1c0f1);
        $display("back to back test done");
    endtask
    task automatic t_abort();
        fmt <= 1'b0;
        host_u.pins(1'b0, 1'b0, 0);
        wait_busy(1'b1);
        host_u.pins(1'b1, 1'b0, 10);
        host_u.pins(1'b0, 1'b0, 0);
        wait_busy(1'b0);
        check(18'(n < 60), 18'h1);
        repeat (4) @(negedge clk);
        check({nap, smp}, 18'h0);
        host_u.read(18, d);
        check(d, `ABORT_CODE);
        $display("abort test done");
    endtask
    task automatic t_pd();
        convert();
        pd <= 1'b1;
        repeat (10) @(negedge clk);
        check({busy, nap, smp}, 18'h0);
        pd <= 1'b0;
        repeat (10) @(posedge clk);
        $display("power down test done");
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        pd = 1'b0;
        fmt = 1'b0;
        core = 18'h00000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_nap(1'b0, 18'h15a3c);
        t_nap(1'b1, 18'h2a5c3);
        t_b2b();
        t_abort();
        t_pd();
        wrap_up();
    end
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule
